// ==== fault_flags_pkg.sv ====
package fault_flags_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF       = 8'h00;
  localparam logic [7:0] CMD_OFF        = 8'h04;
  localparam logic [7:0] FLAGS_OFF      = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFF   = 8'h10;

  // Control register fields
  localparam int CTRL_THERMAL_OFF_DIS_BIT = 0;
  localparam int CTRL_CLK_SRC_SEL_BIT     = 1;
  localparam logic [1:0] CTRL_RESET       = 2'h0;

  // Command register fields, write-only pulses
  localparam int CMD_CLEAR_FAULTS_BIT = 0;
  localparam int CMD_CLEAR_CLOCK_BIT  = 1;
  localparam int CMD_CHECK_CLOCK_BIT  = 2;

  // Flag positions, shared by flag, irq status and irq mask registers
  localparam int FLAG_WARN_BIT     = 0;
  localparam int FLAG_SHUTDOWN_BIT = 1;
  localparam int FLAG_SHORT_BIT    = 2;
  localparam int FLAG_OPEN_BIT     = 3;
  localparam int FLAG_NEIGHBOUR_BIT = 4;
  localparam int FLAG_SUPPLY_BIT   = 5;
  localparam int FLAG_CLOCK_BIT    = 6;
  localparam int NUM_FLAGS         = 7;
  localparam int NUM_FAULTS        = 6;
  localparam logic [6:0] FLAGS_POR_VALUE = 7'h7F;
  localparam logic [6:0] IRQ_MASK_RESET  = 7'h00;

  // Synchroniser input positions
  localparam int IN_WARN     = 0;
  localparam int IN_SHUTDOWN = 1;
  localparam int IN_SHORT    = 2;
  localparam int IN_OPEN     = 3;
  localparam int IN_NEIGHBOUR = 4;
  localparam int IN_SUPPLY   = 5;
  localparam int IN_HW_INIT_N = 6;
  localparam int IN_SUPPLY_INIT = 7;
  localparam int IN_INT_OSC  = 8;
  localparam int IN_EXT_CLK  = 9;
  localparam int NUM_INPUTS  = 10;

  // Clock monitor window
  localparam int CLK_PERIOD_NS     = 4;
  localparam int CLK_WINDOW_NS     = 1000;
  localparam int CLK_WINDOW_CYCLES = CLK_WINDOW_NS / CLK_PERIOD_NS;
  localparam int GAP_W             = 9;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== fault_flags.sv ====
// Contract
// - Warning flag sets when the 125 C detector reports.
// - Shutdown flag sets when the 150 C detector reports.
// - Six fault flags stay at one until an explicit clear.
// - Shutdown flag with thermal-off disable at zero forces every output off.
// - Short flag sets when any output short is reported.
// - Open flag sets when any output open is reported.
// - Neighbour flag sets when any adjacent-output short is reported.
// - Supply flag sets when the supply detector reports a fault.
// - Status read returns all seven flags; controller must issue it.
// - Power-on init from pin or supply monitor sets all seven flags.
// - Clear-status command zeroes the six fault flags.
// - Clock monitor watches internal oscillator on select zero, external on one.
// - After check start, clock flag follows absence of the selected clock.
// - Clear-clock command zeroes the clock fault flag.
module fault_flags (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Detector levels, asynchronous
  input  wire logic        temp_warn_det,
  input  wire logic        temp_shutdown_det,
  input  wire logic        short_det,
  input  wire logic        open_det,
  input  wire logic        neighbour_det,
  input  wire logic        led_supply_det,
  // Power-on init sources, asynchronous
  input  wire logic        hw_init_pin_n,
  input  wire logic        supply_monitor_init,
  // Watched clocks, sampled as plain inputs
  input  wire logic        int_osc_clk,
  input  wire logic        ext_clk,
  // Outputs
  output logic             led_force_off,
  output logic             irq
);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  localparam int NI = fault_flags_pkg::NUM_INPUTS;
  localparam int NF = fault_flags_pkg::NUM_FLAGS;
  localparam int NX = fault_flags_pkg::NUM_FAULTS;
  localparam logic [8:0] WINDOW = 9'(fault_flags_pkg::CLK_WINDOW_CYCLES);

  logic [NI-1:0] raw_in;
  logic [NI-1:0] s1_r;
  logic [NI-1:0] s2_r;
  logic [NI-1:0] s3_r;
  logic [NI-1:0] filt_r;

  assign raw_in = {ext_clk, int_osc_clk, supply_monitor_init, hw_init_pin_n,
                   led_supply_det, neighbour_det, open_det, short_det,
                   temp_shutdown_det, temp_warn_det};

  // Three-stage synchronisers, change accepted when stages two and three agree
  for (genvar i = 0; i < NI; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        {s1_r[i], s2_r[i], s3_r[i], filt_r[i]} <= 4'h0;
      end else begin
        s1_r[i] <= raw_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          filt_r[i] <= s3_r[i];
        end
      end
    end
  end

  logic [NX-1:0] det;
  logic          por_req;
  assign det     = filt_r[NX-1:0];
  assign por_req = !filt_r[fault_flags_pkg::IN_HW_INIT_N]
                 || filt_r[fault_flags_pkg::IN_SUPPLY_INIT];

  // Register state
  logic [1:0]    ctrl_r;
  logic [NF-1:0] flags_r;
  logic [NF-1:0] flags_d_r;
  logic [NF-1:0] irq_stat_r;
  logic [NF-1:0] irq_mask_r;
  logic          clr_faults_r;
  logic          clr_clock_r;
  logic          check_start_r;
  logic          check_on_r;
  logic          thermal_off_disable;
  logic          clock_source_select;

  assign thermal_off_disable = ctrl_r[fault_flags_pkg::CTRL_THERMAL_OFF_DIS_BIT];
  assign clock_source_select = ctrl_r[fault_flags_pkg::CTRL_CLK_SRC_SEL_BIT];

  // AXI write side
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        wr_go;

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_go         = aw_got_r && w_got_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_got_r, w_got_r} <= 2'h0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= fault_flags_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        case (awaddr_r)
          fault_flags_pkg::CTRL_OFF, fault_flags_pkg::CMD_OFF,
          fault_flags_pkg::FLAGS_OFF, fault_flags_pkg::IRQ_STATUS_OFF,
          fault_flags_pkg::IRQ_MASK_OFF: bresp_r <= fault_flags_pkg::RESP_OKAY;
          default: bresp_r <= fault_flags_pkg::RESP_SLVERR;
        endcase
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  logic wr_byte0;
  assign wr_byte0 = wr_go && wstrb_r[0];

  // Control register and one-cycle command pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r        <= fault_flags_pkg::CTRL_RESET;
      {clr_faults_r, clr_clock_r, check_start_r} <= 3'h0;
    end else begin
      {clr_faults_r, clr_clock_r, check_start_r} <= 3'h0;
      if (wr_byte0 && awaddr_r == fault_flags_pkg::CTRL_OFF) begin
        ctrl_r <= wdata_r[1:0];
      end
      if (wr_byte0 && awaddr_r == fault_flags_pkg::CMD_OFF) begin
        clr_faults_r  <= wdata_r[fault_flags_pkg::CMD_CLEAR_FAULTS_BIT];
        clr_clock_r   <= wdata_r[fault_flags_pkg::CMD_CLEAR_CLOCK_BIT];
        check_start_r <= wdata_r[fault_flags_pkg::CMD_CHECK_CLOCK_BIT];
      end
    end
  end

  // Clock monitor
  logic       osc_prev_r;
  logic       ext_prev_r;
  logic       sel_edge;
  logic [8:0] gap_r;
  logic       clk_absent;

  assign sel_edge = clock_source_select
                  ? (filt_r[fault_flags_pkg::IN_EXT_CLK] ^ ext_prev_r)
                  : (filt_r[fault_flags_pkg::IN_INT_OSC] ^ osc_prev_r);
  assign clk_absent = (gap_r == WINDOW);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {osc_prev_r, ext_prev_r} <= 2'h0;
      gap_r      <= 9'h000;
      check_on_r <= 1'b0;
    end else begin
      osc_prev_r <= filt_r[fault_flags_pkg::IN_INT_OSC];
      ext_prev_r <= filt_r[fault_flags_pkg::IN_EXT_CLK];
      if (sel_edge || check_start_r) begin
        gap_r <= 9'h000;
      end else if (!clk_absent) begin
        gap_r <= gap_r + 9'h001;
      end
      if (por_req) begin
        check_on_r <= 1'b0;
      end else if (check_start_r) begin
        check_on_r <= 1'b1;
      end
    end
  end

  // Fault flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn || por_req) begin
      flags_r <= fault_flags_pkg::FLAGS_POR_VALUE;
    end else begin
      flags_r[NX-1:0] <= (clr_faults_r ? '0 : flags_r[NX-1:0]) | det;
      if (check_on_r && clk_absent) begin
        flags_r[fault_flags_pkg::FLAG_CLOCK_BIT] <= 1'b1;
      end else if (clr_clock_r || check_on_r) begin
        flags_r[fault_flags_pkg::FLAG_CLOCK_BIT] <= 1'b0;
      end
    end
  end

  assign led_force_off = !thermal_off_disable
                       && flags_r[fault_flags_pkg::FLAG_SHUTDOWN_BIT];

  // Interrupt status, write one to clear, new event wins
  logic [NF-1:0] irq_w1c;
  assign irq_w1c = (wr_byte0 && awaddr_r == fault_flags_pkg::IRQ_STATUS_OFF)
                 ? wdata_r[NF-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_d_r  <= fault_flags_pkg::FLAGS_POR_VALUE;
      irq_stat_r <= '0;
      irq_mask_r <= fault_flags_pkg::IRQ_MASK_RESET;
    end else begin
      flags_d_r  <= flags_r;
      irq_stat_r <= (irq_stat_r & ~irq_w1c) | (flags_r & ~flags_d_r);
      if (wr_byte0 && awaddr_r == fault_flags_pkg::IRQ_MASK_OFF) begin
        irq_mask_r <= wdata_r[NF-1:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // AXI read side
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= fault_flags_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= fault_flags_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fault_flags_pkg::CTRL_OFF:       rdata_r <= {30'h0, ctrl_r};
        fault_flags_pkg::CMD_OFF:        rdata_r <= 32'h0000_0000;
        fault_flags_pkg::FLAGS_OFF:      rdata_r <= {25'h0, flags_r};
        fault_flags_pkg::IRQ_STATUS_OFF: rdata_r <= {25'h0, irq_stat_r};
        fault_flags_pkg::IRQ_MASK_OFF:   rdata_r <= {25'h0, irq_mask_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= fault_flags_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Assertions
  sequence flags_read_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == fault_flags_pkg::FLAGS_OFF;
  endsequence
  sequence clock_lost_s;
    check_on_r && clk_absent && !por_req;
  endsequence
  AST_WARN_SET: assert property (det[fault_flags_pkg::IN_WARN] |=>
    flags_r[fault_flags_pkg::FLAG_WARN_BIT]) else $error("warning flag not set");
  AST_SHUTDOWN_SET: assert property (det[fault_flags_pkg::IN_SHUTDOWN] |=>
    flags_r[fault_flags_pkg::FLAG_SHUTDOWN_BIT]) else $error("shutdown flag not set");
  AST_STICKY: assert property (!clr_faults_r |=>
    &(flags_r[NX-1:0] | ~$past(flags_r[NX-1:0]))) else $error("fault flag dropped");
  AST_FORCE_OFF: assert property (det[fault_flags_pkg::IN_SHUTDOWN] |=>
    led_force_off || thermal_off_disable) else $error("output force-off wrong");
  AST_SHORT_SET: assert property (det[fault_flags_pkg::IN_SHORT] |=>
    flags_r[fault_flags_pkg::FLAG_SHORT_BIT]) else $error("short flag not set");
  AST_OPEN_SET: assert property (det[fault_flags_pkg::IN_OPEN] |=>
    flags_r[fault_flags_pkg::FLAG_OPEN_BIT]) else $error("open flag not set");
  AST_NEIGHBOUR_SET: assert property (det[fault_flags_pkg::IN_NEIGHBOUR] |=>
    flags_r[fault_flags_pkg::FLAG_NEIGHBOUR_BIT]) else $error("neighbour flag not set");
  AST_SUPPLY_SET: assert property (det[fault_flags_pkg::IN_SUPPLY] |=>
    flags_r[fault_flags_pkg::FLAG_SUPPLY_BIT]) else $error("supply flag not set");
  AST_READ_FLAGS: assert property (flags_read_s |=> s_axi_rvalid &&
    s_axi_rdata[NF-1:0] == $past(flags_r)) else $error("flag read data wrong");
  AST_POR_SET: assert property (por_req |=>
    flags_r == fault_flags_pkg::FLAGS_POR_VALUE) else $error("init did not set all flags");
  AST_CLEAR: assert property (clr_faults_r && !por_req |=>
    flags_r[NX-1:0] == $past(det)) else $error("clear did not zero idle flags");
  AST_SRC_SEL: assert property (!clock_source_select && osc_prev_r !=
    filt_r[fault_flags_pkg::IN_INT_OSC] |=> gap_r == 9'h000) else $error("osc edge missed");
  AST_SRC_SEL_EXT: assert property (clock_source_select && ext_prev_r !=
    filt_r[fault_flags_pkg::IN_EXT_CLK] |=> gap_r == 9'h000) else $error("ext edge missed");
  AST_CLK_LOST: assert property (clock_lost_s |=>
    flags_r[fault_flags_pkg::FLAG_CLOCK_BIT]) else $error("clock fault not raised");
  AST_CLK_CLEAR: assert property (clr_clock_r && !por_req && !(check_on_r && clk_absent)
    |=> !flags_r[fault_flags_pkg::FLAG_CLOCK_BIT]) else $error("clock fault not cleared");
  AST_SET_WINS: assert property (clr_faults_r && det != '0 |=>
    (flags_r[NX-1:0] & $past(det)) == $past(det)) else $error("clear beat a detection");
  AST_WINDOW: assert property (sel_edge |=> gap_r == 9'h000)
    else $error("gap counter not restarted on edge");
  AST_WINDOW_FULL: assert property (gap_r == WINDOW - 9'h001 && !sel_edge && !check_start_r
    |=> clk_absent) else $error("window end not flagged");

endmodule

// ==== host_model.sv ====
// Bus master standing in for the controller
module host_model (
  // Clock
  input  wire logic        aclk,
  // Write address and data
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  // Write response
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read address and data
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_open;
    logic w_open;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_open = 1'b1;
    w_open  = 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && awready) begin
        awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && wready) begin
        wvalid <= 1'b0;
        w_open = 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Status read: all seven flags in one word
  task automatic read_flags(output logic [31:0] d);
    logic [1:0] resp;
    rd(fault_flags_pkg::FLAGS_OFF, d, resp);
  endtask

  // Clears the six fault flags
  task automatic clear_faults();
    logic [1:0] resp;
    wr(fault_flags_pkg::CMD_OFF, 32'h1, resp);
  endtask
endmodule

// ==== sticky_fault_status_flags_bench.sv ====
module sticky_fault_status_flags_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [5:0] det; logic [31:0] exp; } row_t;
  logic        aclk, aresetn, hw_init_pin_n, supply_monitor_init, int_osc_clk, ext_clk;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, led_force_off, irq, osc_run, ext_run;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  det;
  logic [2:0]  div;
  int          err_count, tests_run, cycles;
  row_t        rows [7] = '{
    '{6'h01, 32'h01},
    '{6'h02, 32'h02},
    '{6'h04, 32'h04},
    '{6'h08, 32'h08},
    '{6'h10, 32'h10},
    '{6'h20, 32'h20},
    '{6'h3F, 32'h3F}
  };

  fault_flags fault_flags_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .temp_warn_det(det[0]), .temp_shutdown_det(det[1]), .short_det(det[2]),
    .open_det(det[3]), .neighbour_det(det[4]), .led_supply_det(det[5]),
    .hw_init_pin_n(hw_init_pin_n), .supply_monitor_init(supply_monitor_init),
    .int_osc_clk(int_osc_clk), .ext_clk(ext_clk),
    .led_force_off(led_force_off), .irq(irq)
  );

  host_model host_model_inst (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  // Watched clocks toggle every 5 cycles while running
  always @(posedge aclk) begin
    div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
    if (div == 3'h4 && osc_run) int_osc_clk <= ~int_osc_clk;
    if (div == 3'h4 && ext_run) ext_clk <= ~ext_clk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic put(input logic [7:0] a, input logic [31:0] v);
    host_model_inst.wr(a, v, r);
  endtask

  task automatic flags_after(input int n, input logic [31:0] m, input logic [31:0] exp);
    cyc(n);
    host_model_inst.read_flags(d);
    chk(d & m, exp);
  endtask

  initial begin
    {aresetn, det, supply_monitor_init, osc_run, ext_run, int_osc_clk, ext_clk} = '0;
    {div, cycles, err_count, tests_run} = '0;
    hw_init_pin_n = 1'b1;
    cyc(8);
    aresetn <= 1'b1;
    flags_after(10, 32'hFF, 32'h7F);
    chk({31'h0, led_force_off}, 32'h1);
    host_model_inst.clear_faults();
    flags_after(3, 32'hFF, 32'h40);
    put(fault_flags_pkg::CMD_OFF, 32'h2);
    flags_after(3, 32'hFF, 32'h00);
    for (int i = 0; i < 7; i++) begin
      det <= rows[i].det;
      cyc(8);
      det <= 6'h00;
      flags_after(8, 32'hFF, rows[i].exp);
      host_model_inst.clear_faults();
      flags_after(3, 32'hFF, 32'h00);
    end
    // Thermal shutdown forces outputs off unless disabled
    det <= 6'h02;
    cyc(8);
    det <= 6'h00;
    cyc(2);
    chk({31'h0, led_force_off}, 32'h1);
    put(fault_flags_pkg::CTRL_OFF, 32'h1);
    chk({30'h0, r}, 32'h0);
    cyc(2);
    chk({31'h0, led_force_off}, 32'h0);
    put(fault_flags_pkg::CTRL_OFF, 32'h0);
    cyc(2);
    chk({31'h0, led_force_off}, 32'h1);
    // Clear while a detector stays active
    det <= 6'h01;
    cyc(8);
    host_model_inst.clear_faults();
    flags_after(3, 32'hFF, 32'h01);
    det <= 6'h00;
    cyc(8);
    host_model_inst.clear_faults();
    // Interrupt raise, mask, clear
    put(fault_flags_pkg::IRQ_STATUS_OFF, 32'h7F);
    put(fault_flags_pkg::IRQ_MASK_OFF, 32'h7F);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    det <= 6'h04;
    cyc(8);
    det <= 6'h00;
    chk({31'h0, irq}, 32'h1);
    host_model_inst.rd(fault_flags_pkg::IRQ_STATUS_OFF, d, r);
    chk(d, 32'h04);
    put(fault_flags_pkg::IRQ_MASK_OFF, 32'h7B);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    put(fault_flags_pkg::IRQ_MASK_OFF, 32'h7F);
    put(fault_flags_pkg::IRQ_STATUS_OFF, 32'h04);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    // Unmapped and write-only places
    host_model_inst.rd(8'h20, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    host_model_inst.rd(fault_flags_pkg::CMD_OFF, d, r);
    chk(d, 32'h0);
    put(8'h20, 32'h0);
    chk({30'h0, r}, 32'h2);
    // Reset in mid-run puts every flag back to one
    aresetn <= 1'b0;
    cyc(8);
    aresetn <= 1'b1;
    flags_after(10, 32'hFF, 32'h7F);
    chk({31'h0, irq}, 32'h0);
    // Init from the pin and from the supply monitor
    host_model_inst.clear_faults();
    hw_init_pin_n <= 1'b0;
    cyc(8);
    hw_init_pin_n <= 1'b1;
    flags_after(10, 32'hFF, 32'h7F);
    host_model_inst.clear_faults();
    supply_monitor_init <= 1'b1;
    cyc(8);
    supply_monitor_init <= 1'b0;
    flags_after(10, 32'hFF, 32'h7F);
    host_model_inst.clear_faults();
    // Clock monitor on each source
    osc_run <= 1'b1;
    put(fault_flags_pkg::CMD_OFF, 32'h2);
    put(fault_flags_pkg::CMD_OFF, 32'h4);
    flags_after(300, 32'h40, 32'h00);
    osc_run <= 1'b0;
    flags_after(300, 32'h40, 32'h40);
    osc_run <= 1'b1;
    flags_after(300, 32'h40, 32'h00);
    put(fault_flags_pkg::CTRL_OFF, 32'h2);
    flags_after(300, 32'h40, 32'h40);
    ext_run <= 1'b1;
    flags_after(300, 32'h40, 32'h00);
    end_of_test();
  end
endmodule
